// file: gcb_pkg.sv
`default_nettype none
package gcb_pkg;
	localparam int ADDR_W = 8;
	localparam int ORG_W = 24;
	typedef logic [ADDR_W-1:0] gcb_addr_t;
	typedef logic [2:0] gcb_mode_t;
	typedef logic [1:0] gcb_sel_t;
	typedef logic [3:0] gcb_res_t;
	typedef logic [4:0] gcb_pnum_t;
	typedef logic [2:0] gcb_nav_t;

	localparam gcb_addr_t OFS_MODE = 8'h00;
	localparam gcb_addr_t OFS_ORIGDET = 8'h04;
	localparam gcb_addr_t OFS_UNIT = 8'h08;
	localparam gcb_addr_t OFS_PITCH = 8'h0C;
	localparam gcb_addr_t OFS_DIR = 8'h10;
	localparam gcb_addr_t OFS_RES_A = 8'h14;
	localparam gcb_addr_t OFS_RES_B = 8'h18;
	localparam gcb_addr_t OFS_ABS = 8'h1C;
	localparam gcb_addr_t OFS_ABS_ORG = 8'h20;
	localparam gcb_addr_t OFS_PRESET = 8'h24;
	localparam gcb_addr_t OFS_TOL = 8'h28;
	localparam gcb_addr_t OFS_NAV = 8'h2C;

	localparam gcb_mode_t MODE_SET = 3'h0;
	localparam gcb_mode_t MODE_CELL = 3'h1;
	localparam gcb_mode_t MODE_CONST = 3'h2;
	localparam gcb_mode_t MODE_SAVE = 3'h3;
	localparam gcb_mode_t MODE_LOAD = 3'h4;

	localparam gcb_sel_t UNIT_MM = 2'h0;
	localparam gcb_sel_t UNIT_IN_5 = 2'h1;
	localparam gcb_sel_t UNIT_IN_1 = 2'h2;
	localparam gcb_sel_t UNIT_MM_IN = 2'h3;

	localparam gcb_sel_t PITCH_MAX = 2'h2;
	localparam gcb_res_t RES_SPAN = 4'h4;
	localparam gcb_res_t RES_MAX = 4'h8;

	localparam gcb_sel_t DEF_UNIT = 2'h0;
	localparam gcb_sel_t DEF_PITCH = 2'h1;
	localparam gcb_sel_t DEF_DIR = 2'h0;
	localparam gcb_res_t DEF_RES = 4'h6;
	localparam gcb_nav_t NAV_LAST = 3'h5;
	localparam int NAV_ACT_BIT = 8;

	localparam logic [7:0] NV_TAG = 8'hA5;
	localparam logic [1:0] NV_SLOT_IMG = 2'h0;
	localparam logic [1:0] NV_SLOT_ORG = 2'h1;

	typedef enum logic [2:0] {
		GCB_S_BOOT = 3'h1,
		GCB_S_ORG = 3'h2,
		GCB_S_RUN = 3'h4
	} gcb_state_e;

	typedef struct packed {
		logic [7:0] tag;
		logic [7:0] spare;
		logic abs_mode;
		gcb_res_t res_b;
		gcb_res_t res_a;
		gcb_sel_t dir;
		gcb_sel_t pitch;
		gcb_sel_t unit;
		logic orig;
	} gcb_img_s;

	typedef struct packed {
		logic [7:0] tag;
		logic [ORG_W-1:0] origin;
	} gcb_org_s;

	function automatic logic res_ok(gcb_sel_t pitch, gcb_res_t code);
		gcb_res_t lo;
		lo = gcb_res_t'({pitch, 1'b0});
		return (code >= lo) && (code <= gcb_res_t'(lo + RES_SPAN));
	endfunction : res_ok

	function automatic gcb_pnum_t nav_num(gcb_nav_t idx);
		case (idx)
			3'h0: return 5'h00;
			3'h1: return 5'h05;
			3'h2: return 5'h09;
			3'h3: return 5'h0A;
			3'h4: return 5'h0B;
			default: return 5'h0C;
		endcase
	endfunction : nav_num
endpackage : gcb_pkg
`default_nettype wire

// file: gcb_nvstore.sv
`timescale 1ns/1ps
`default_nettype none
// Retained store: no reset on purpose, contents outlive a reset
module gcb_nvstore #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 32
) (
	// Clock
	input wire logic clk,
	input wire logic ce,
	// Write port
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port
	input wire logic [1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule : gcb_nvstore
`default_nettype wire

// file: gcb_basic_params.sv
`timescale 1ns/1ps
`default_nettype none
module gcb_basic_params (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gcb_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Front panel and gauge
	input wire logic pset_key_n,
	input wire logic [gcb_pkg::ORG_W-1:0] gauge_count,
	// Settings to the counting datapath
	output logic [2:0] param_mode,
	output logic origin_detect_en,
	output logic [1:0] unit_sel,
	output logic [1:0] signal_pitch,
	output logic [1:0] count_dir,
	output logic [3:0] res_a,
	output logic [3:0] res_b,
	output logic absolute_origin_mode,
	output logic [gcb_pkg::ORG_W-1:0] abs_origin,
	output logic [31:0] preset_val,
	output logic [31:0] tol_val,
	output logic [4:0] param_number,
	output logic boot_done
);
	gcb_pkg::gcb_state_e st_q, st_d;
	gcb_pkg::gcb_mode_t mode_q, mode_d;
	gcb_pkg::gcb_sel_t unit_q, unit_d, pitch_q, pitch_d, dir_q, dir_d;
	gcb_pkg::gcb_res_t ra_q, ra_d, rb_q, rb_d;
	gcb_pkg::gcb_nav_t nav_q, nav_d;
	gcb_pkg::gcb_img_s img_rd, img_wr;
	gcb_pkg::gcb_org_s org_rd;
	logic orig_q, orig_d, abs_q, abs_d;
	logic boot_q, boot_d;
	gcb_pkg::gcb_pnum_t pnum_q, pnum_d;
	logic nav_act_q, nav_act_d;
	logic [gcb_pkg::ORG_W-1:0] org_q, org_d;
	logic [31:0] preset_q, preset_d, tol_q, tol_d, prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic key1_q, key2_q, keyp_q, key_press, wr_fire;
	logic nv_we;
	logic [1:0] nv_waddr, nv_raddr;
	logic [31:0] nv_wdata, nv_rdata;

	gcb_nvstore #(
		.DEPTH(4),
		.WIDTH(32)
	) u_nv (
		.clk(pclk),
		.ce(ce),
		.we(nv_we),
		.waddr(nv_waddr),
		.wdata(nv_wdata),
		.raddr(nv_raddr),
		.rdata(nv_rdata)
	);

	// Second sync stage only feeds the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key1_q <= 1'b1;
			key2_q <= 1'b1;
			keyp_q <= 1'b1;
		end else if (ce) begin
			key1_q <= pset_key_n;
			key2_q <= key1_q;
			keyp_q <= key2_q;
		end
	end
	assign key_press = keyp_q && !key2_q;

	// Boot reads image first, origin in the next state
	assign nv_raddr = (st_q == gcb_pkg::GCB_S_BOOT) ? gcb_pkg::NV_SLOT_IMG :
		((st_q == gcb_pkg::GCB_S_ORG) ? gcb_pkg::NV_SLOT_ORG :
		gcb_pkg::NV_SLOT_IMG);
	assign img_rd = gcb_pkg::gcb_img_s'(nv_rdata);
	assign org_rd = gcb_pkg::gcb_org_s'(nv_rdata);
	assign wr_fire = ce && psel && penable && pready_q && pwrite &&
		!pslverr_q;
	always_comb begin
		img_wr = '0;
		img_wr.tag = gcb_pkg::NV_TAG;
		img_wr.abs_mode = abs_q;
		img_wr.res_b = rb_q;
		img_wr.res_a = ra_q;
		img_wr.dir = dir_q;
		img_wr.pitch = pitch_q;
		img_wr.unit = unit_q;
		img_wr.orig = orig_q;
	end

	// APB answer: one setup plus one access cycle, pready held low until boot ends
	always_comb begin
		pready_d = psel && !pready_q && (st_q == gcb_pkg::GCB_S_RUN);
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (pready_d) begin
			prdata_d = '0;
			if (paddr == gcb_pkg::OFS_MODE) begin
				prdata_d = 32'(mode_q);
				pslverr_d = pwrite && (pwdata > 32'(gcb_pkg::MODE_LOAD));
			end else if (paddr == gcb_pkg::OFS_ORIGDET) begin
				prdata_d = 32'(orig_q);
			end else if (paddr == gcb_pkg::OFS_UNIT) begin
				prdata_d = 32'(unit_q);
			end else if (paddr == gcb_pkg::OFS_PITCH) begin
				prdata_d = 32'(pitch_q);
				pslverr_d = pwrite && (pwdata > 32'(gcb_pkg::PITCH_MAX));
			end else if (paddr == gcb_pkg::OFS_DIR) begin
				prdata_d = 32'(dir_q);
			end else if (paddr == gcb_pkg::OFS_RES_A) begin
				prdata_d = 32'(ra_q);
				pslverr_d = pwrite && ((pwdata > 32'(gcb_pkg::RES_MAX)) ||
					!gcb_pkg::res_ok(pitch_q, gcb_pkg::gcb_res_t'(pwdata)));
			end else if (paddr == gcb_pkg::OFS_RES_B) begin
				prdata_d = 32'(rb_q);
				pslverr_d = pwrite && ((pwdata > 32'(gcb_pkg::RES_MAX)) ||
					!gcb_pkg::res_ok(pitch_q, gcb_pkg::gcb_res_t'(pwdata)));
			end else if (paddr == gcb_pkg::OFS_ABS) begin
				prdata_d = 32'(abs_q);
			end else if (paddr == gcb_pkg::OFS_ABS_ORG) begin
				prdata_d = 32'(org_q);
				pslverr_d = pwrite;
			end else if (paddr == gcb_pkg::OFS_PRESET) begin
				prdata_d = preset_q;
			end else if (paddr == gcb_pkg::OFS_TOL) begin
				prdata_d = tol_q;
			end else if (paddr == gcb_pkg::OFS_NAV) begin
				prdata_d = {23'h0, nav_act_q, 3'h0, gcb_pkg::nav_num(nav_q)};
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	// Settings, boot sequence and key navigation
	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		orig_d = orig_q;
		unit_d = unit_q;
		pitch_d = pitch_q;
		dir_d = dir_q;
		ra_d = ra_q;
		rb_d = rb_q;
		abs_d = abs_q;
		org_d = org_q;
		preset_d = preset_q;
		tol_d = tol_q;
		nav_d = nav_q;
		nav_act_d = nav_act_q;
		nv_we = 1'b0;
		nv_waddr = gcb_pkg::NV_SLOT_IMG;
		nv_wdata = img_wr;
		case (st_q)
			gcb_pkg::GCB_S_BOOT: begin
				if (img_rd.tag == gcb_pkg::NV_TAG) begin
					orig_d = img_rd.orig;
					unit_d = img_rd.unit;
					pitch_d = img_rd.pitch;
					dir_d = img_rd.dir;
					ra_d = img_rd.res_a;
					rb_d = img_rd.res_b;
					abs_d = img_rd.abs_mode;
				end
				st_d = gcb_pkg::GCB_S_ORG;
			end
			gcb_pkg::GCB_S_ORG: begin
				if (org_rd.tag == gcb_pkg::NV_TAG) begin
					org_d = org_rd.origin;
				end else if (abs_q) begin
					org_d = gauge_count;
					nv_we = 1'b1;
					nv_waddr = gcb_pkg::NV_SLOT_ORG;
					nv_wdata = {gcb_pkg::NV_TAG, gauge_count};
				end
				st_d = gcb_pkg::GCB_S_RUN;
			end
			gcb_pkg::GCB_S_RUN: begin
				if (wr_fire) begin
					if (paddr == gcb_pkg::OFS_MODE) begin
						mode_d = gcb_pkg::gcb_mode_t'(pwdata);
						if (mode_d == gcb_pkg::MODE_SAVE) begin
							nv_we = 1'b1;
						end
					end else if (paddr == gcb_pkg::OFS_ORIGDET) begin
						orig_d = pwdata[0];
					end else if (paddr == gcb_pkg::OFS_UNIT) begin
						unit_d = gcb_pkg::gcb_sel_t'(pwdata);
						orig_d = 1'b0;
						pitch_d = gcb_pkg::DEF_PITCH;
						dir_d = gcb_pkg::DEF_DIR;
						ra_d = gcb_pkg::DEF_RES;
						rb_d = gcb_pkg::DEF_RES;
						abs_d = 1'b0;
						preset_d = '0;
						tol_d = '0;
					end else if (paddr == gcb_pkg::OFS_PITCH) begin
						pitch_d = gcb_pkg::gcb_sel_t'(pwdata);
						// A stale code would leave the axis unusable
						if (!gcb_pkg::res_ok(pitch_d, ra_q)) begin
							ra_d = gcb_pkg::gcb_res_t'({pitch_d, 1'b0});
						end
						if (!gcb_pkg::res_ok(pitch_d, rb_q)) begin
							rb_d = gcb_pkg::gcb_res_t'({pitch_d, 1'b0});
						end
					end else if (paddr == gcb_pkg::OFS_DIR) begin
						dir_d = gcb_pkg::gcb_sel_t'(pwdata);
					end else if (paddr == gcb_pkg::OFS_RES_A) begin
						ra_d = gcb_pkg::gcb_res_t'(pwdata);
					end else if (paddr == gcb_pkg::OFS_RES_B) begin
						rb_d = gcb_pkg::gcb_res_t'(pwdata);
					end else if (paddr == gcb_pkg::OFS_ABS) begin
						abs_d = pwdata[0];
					end else if (paddr == gcb_pkg::OFS_PRESET) begin
						preset_d = pwdata;
					end else if (paddr == gcb_pkg::OFS_TOL) begin
						tol_d = pwdata;
					end else if (paddr == gcb_pkg::OFS_NAV) begin
						nav_act_d = pwdata[gcb_pkg::NAV_ACT_BIT];
						nav_d = '0;
					end
				end
				if (wr_fire && paddr == gcb_pkg::OFS_MODE &&
					mode_d == gcb_pkg::MODE_LOAD &&
					img_rd.tag == gcb_pkg::NV_TAG) begin
					orig_d = img_rd.orig;
					unit_d = img_rd.unit;
					pitch_d = img_rd.pitch;
					dir_d = img_rd.dir;
					ra_d = img_rd.res_a;
					rb_d = img_rd.res_b;
					abs_d = img_rd.abs_mode;
				end
				if (pitch_d != pitch_q || ra_d != ra_q || rb_d != rb_q) begin
					preset_d = '0;
					tol_d = '0;
				end
				if (key_press && nav_act_q && !wr_fire) begin
					nav_d = (nav_q == gcb_pkg::NAV_LAST) ? '0 :
						gcb_pkg::gcb_nav_t'(nav_q + 3'h1);
				end
			end
			default: st_d = gcb_pkg::GCB_S_BOOT;
		endcase
		// Decoded ahead so the pins leave straight from flops
		pnum_d = gcb_pkg::nav_num(nav_d);
		boot_d = (st_d == gcb_pkg::GCB_S_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= gcb_pkg::GCB_S_BOOT;
			mode_q <= gcb_pkg::MODE_SET;
			orig_q <= 1'b0;
			unit_q <= gcb_pkg::DEF_UNIT;
			pitch_q <= gcb_pkg::DEF_PITCH;
			dir_q <= gcb_pkg::DEF_DIR;
			ra_q <= gcb_pkg::DEF_RES;
			rb_q <= gcb_pkg::DEF_RES;
			abs_q <= 1'b0;
			org_q <= '0;
			preset_q <= '0;
			tol_q <= '0;
			nav_q <= '0;
			nav_act_q <= 1'b0;
			pnum_q <= '0;
			boot_q <= 1'b0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			mode_q <= mode_d;
			orig_q <= orig_d;
			unit_q <= unit_d;
			pitch_q <= pitch_d;
			dir_q <= dir_d;
			ra_q <= ra_d;
			rb_q <= rb_d;
			abs_q <= abs_d;
			org_q <= org_d;
			preset_q <= preset_d;
			tol_q <= tol_d;
			nav_q <= nav_d;
			nav_act_q <= nav_act_d;
			pnum_q <= pnum_d;
			boot_q <= boot_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign param_mode = mode_q;
	assign origin_detect_en = orig_q;
	assign unit_sel = unit_q;
	assign signal_pitch = pitch_q;
	assign count_dir = dir_q;
	assign res_a = ra_q;
	assign res_b = rb_q;
	assign absolute_origin_mode = abs_q;
	assign abs_origin = org_q;
	assign preset_val = preset_q;
	assign tol_val = tol_q;
	assign param_number = pnum_q;
	assign boot_done = boot_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_MODE_RANGE: assert property (mode_q <= gcb_pkg::MODE_LOAD)
		else $error("mode code out of range");
	AST_ORIG_WRITE: assert property (wr_fire && paddr == gcb_pkg::OFS_ORIGDET
		|=> orig_q == $past(pwdata[0]))
		else $error("origin detect bit not stored");
	AST_UNIT_DEFAULTS: assert property (wr_fire && paddr == gcb_pkg::OFS_UNIT
		|=> ra_q == gcb_pkg::DEF_RES && pitch_q == gcb_pkg::DEF_PITCH &&
		dir_q == gcb_pkg::DEF_DIR && preset_q == '0)
		else $error("unit write did not restore defaults");
	AST_RES_LEGAL: assert property (boot_done && $past(boot_done)
		|-> gcb_pkg::res_ok(pitch_q, ra_q) &&
		gcb_pkg::res_ok(pitch_q, rb_q))
		else $error("resolution outside pitch range");
	AST_DIR_WRITE: assert property (wr_fire && paddr == gcb_pkg::OFS_DIR
		|=> dir_q == $past(pwdata[1:0]))
		else $error("direction not stored");
	AST_RES_CLEAR: assert property (ce && (ra_d != ra_q || pitch_d != pitch_q)
		&& boot_done |=> preset_q == '0 && tol_q == '0)
		else $error("preset or tolerance kept after change");
	AST_ORG_STABLE: assert property (boot_done && $past(boot_done)
		|-> org_q == $past(org_q))
		else $error("origin moved while running");
	AST_KEY_ADV: assert property (ce && key_press && nav_act_q && boot_done &&
		!wr_fire && nav_q != gcb_pkg::NAV_LAST
		|=> nav_q == $past(nav_q) + 3'h1)
		else $error("key press did not advance number");
	AST_SAVE_WRITE: assert property (wr_fire && paddr == gcb_pkg::OFS_MODE &&
		pwdata == 32'(gcb_pkg::MODE_SAVE) |-> nv_we)
		else $error("save did not write store");

	COV_SAVE: cover property (nv_we && st_q == gcb_pkg::GCB_S_RUN);
	COV_REJECT: cover property (pready_q && pslverr_q);
	COV_UNIT: cover property (wr_fire && paddr == gcb_pkg::OFS_UNIT);
	COV_KEY_WRAP: cover property (key_press && nav_q == gcb_pkg::NAV_LAST);
endmodule : gcb_basic_params
`default_nettype wire

// file: gcb_gauge_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: an absolute-type gauge and the panel set key
module gcb_gauge_model (
	// Clock
	input wire logic pclk,
	// Panel key and gauge count
	output logic pset_key_n,
	output logic [gcb_pkg::ORG_W-1:0] gauge_count
);
	// Absolute gauge, so the operator may pick either origin mode
	localparam bit GAUGE_IS_ABS = 1'b1;
	initial begin
		pset_key_n = 1'b1;
		gauge_count = 24'h000000;
	end
	// Held low well past the two sync flops so no press is lost
	task automatic press();
		@(posedge pclk);
		pset_key_n <= 1'b0;
		repeat (5) @(posedge pclk);
		pset_key_n <= 1'b1;
		repeat (5) @(posedge pclk);
	endtask : press
	task automatic move(input logic [gcb_pkg::ORG_W-1:0] pos);
		@(posedge pclk);
		gauge_count <= pos;
	endtask : move
endmodule : gcb_gauge_model
`default_nettype wire

// file: test_gauge_counter_basic_params.sv
`timescale 1ns/1ps
`default_nettype none
module test_gauge_counter_basic_params;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, preset_val, tol_val, m_pre, m_tol, rd;
	logic [31:0] m_org = 32'h00000000;
	logic pready, pslverr, pset_key_n, origin_detect_en, boot_done, er;
	logic absolute_origin_mode;
	logic [2:0] param_mode;
	logic [1:0] unit_sel, signal_pitch, count_dir;
	logic [3:0] res_a, res_b;
	logic [gcb_pkg::ORG_W-1:0] gauge_count, abs_origin;
	logic [4:0] param_number;
	int n_fail = 0, checked = 0, cyc = 0, s_ok = 0, org_ok = 0;
	int m_mode, m_orig, m_unit, m_pitch, m_dir, m_ra, m_rb, m_abs;
	int s_orig, s_unit, s_pitch, s_dir, s_ra, s_rb, s_abs, nav_on, nav_idx;
	logic [7:0] adr[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30};
	int lim[12] = '{8, 2, 4, 4, 4, 10, 10, 2, 0, 0, 0, 0};

	always #4 pclk = ~pclk;

	gcb_basic_params dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pset_key_n(pset_key_n),
		.gauge_count(gauge_count), .param_mode(param_mode),
		.origin_detect_en(origin_detect_en), .unit_sel(unit_sel),
		.signal_pitch(signal_pitch), .count_dir(count_dir), .res_a(res_a),
		.res_b(res_b), .absolute_origin_mode(absolute_origin_mode),
		.abs_origin(abs_origin), .preset_val(preset_val), .tol_val(tol_val),
		.param_number(param_number), .boot_done(boot_done));
	gcb_gauge_model model_u (.pclk(pclk), .pset_key_n(pset_key_n),
		.gauge_count(gauge_count));

	task automatic end_sim();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// Ceiling far above the roughly 1000 cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	function automatic int pnum(int i);
		int t[6] = '{0, 5, 9, 10, 11, 12};
		return t[i];
	endfunction : pnum
	function automatic bit legal(int p, int c);
		return c >= 2 * p && c <= 2 * p + 4;
	endfunction : legal
	function automatic int fix(int p, int c);
		return legal(p, c) ? c : 2 * p;
	endfunction : fix

	task automatic apply(int p, int a, int b);
		if (p != m_pitch || a != m_ra || b != m_rb) begin
			m_pre = 32'h00000000;
			m_tol = 32'h00000000;
		end
		m_pitch = p;
		m_ra = a;
		m_rb = b;
	endtask : apply
	task automatic load();
		m_orig = s_orig;
		m_unit = s_unit;
		m_dir = s_dir;
		m_abs = s_abs;
		apply(s_pitch, s_ra, s_rb);
	endtask : load
	task automatic dflt();
		m_orig = 0;
		m_dir = 0;
		m_abs = 0;
		apply(1, 6, 6);
		m_pre = 32'h00000000;
		m_tol = 32'h00000000;
	endtask : dflt
	task automatic m_boot();
		dflt();
		m_mode = 0;
		m_unit = 0;
		nav_on = 0;
		nav_idx = 0;
		if (s_ok != 0) load();
		if (m_abs != 0 && org_ok == 0) begin
			m_org = 32'(gauge_count);
			org_ok = 1;
		end
	endtask : m_boot

	task automatic m_write(input logic [7:0] a, input logic [31:0] d,
		output logic e);
		e = 1'b0;
		case (a)
			gcb_pkg::OFS_MODE: begin
				e = d > 4;
				if (!e) m_mode = int'(d);
				if (!e && d == 3) begin
					s_ok = 1;
					s_orig = m_orig;
					s_unit = m_unit;
					s_dir = m_dir;
					s_pitch = m_pitch;
					s_ra = m_ra;
					s_rb = m_rb;
					s_abs = m_abs;
				end
				if (!e && d == 4 && s_ok != 0) load();
			end
			gcb_pkg::OFS_ORIGDET: m_orig = int'(d[0]);
			gcb_pkg::OFS_UNIT: begin
				dflt();
				m_unit = int'(d[1:0]);
			end
			gcb_pkg::OFS_PITCH: begin
				e = d > 2;
				if (!e) apply(int'(d), fix(int'(d), m_ra), fix(int'(d), m_rb));
			end
			gcb_pkg::OFS_DIR: m_dir = int'(d[1:0]);
			gcb_pkg::OFS_RES_A: begin
				e = !legal(m_pitch, int'(d));
				if (!e) apply(m_pitch, int'(d), m_rb);
			end
			gcb_pkg::OFS_RES_B: begin
				e = !legal(m_pitch, int'(d));
				if (!e) apply(m_pitch, m_ra, int'(d));
			end
			gcb_pkg::OFS_ABS: m_abs = int'(d[0]);
			gcb_pkg::OFS_PRESET: m_pre = d;
			gcb_pkg::OFS_TOL: m_tol = d;
			gcb_pkg::OFS_NAV: begin
				nav_on = int'(d[8]);
				nav_idx = 0;
			end
			default: e = 1'b1;
		endcase
	endtask : m_write

	function automatic logic [32:0] m_read(logic [7:0] a);
		case (a)
			gcb_pkg::OFS_MODE: return 33'(m_mode);
			gcb_pkg::OFS_ORIGDET: return 33'(m_orig);
			gcb_pkg::OFS_UNIT: return 33'(m_unit);
			gcb_pkg::OFS_PITCH: return 33'(m_pitch);
			gcb_pkg::OFS_DIR: return 33'(m_dir);
			gcb_pkg::OFS_RES_A: return 33'(m_ra);
			gcb_pkg::OFS_RES_B: return 33'(m_rb);
			gcb_pkg::OFS_ABS: return 33'(m_abs);
			gcb_pkg::OFS_ABS_ORG: return 33'(m_org);
			gcb_pkg::OFS_PRESET: return {1'b0, m_pre};
			gcb_pkg::OFS_TOL: return {1'b0, m_tol};
			gcb_pkg::OFS_NAV: return 33'(nav_on * 256 + pnum(nav_idx));
			default: return {1'b1, 32'h00000000};
		endcase
	endfunction : m_read

	task automatic outs();
		cmp(32'(param_mode), 32'(m_mode));
		cmp(32'(origin_detect_en), 32'(m_orig));
		cmp(32'(unit_sel), 32'(m_unit));
		cmp(32'(signal_pitch), 32'(m_pitch));
		cmp(32'(count_dir), 32'(m_dir));
		cmp(32'(res_a), 32'(m_ra));
		cmp(32'(res_b), 32'(m_rb));
		cmp(32'(absolute_origin_mode), 32'(m_abs));
		cmp(32'(abs_origin), m_org);
		cmp(preset_val, m_pre);
		cmp(tol_val, m_tol);
		cmp(32'(param_number), 32'(pnum(nav_idx)));
		cmp(32'(boot_done), 32'h00000001);
	endtask : outs

	// Request held until pready is seen high at a rising edge
	task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d);
		logic [32:0] x;
		logic e;
		x = m_read(a);
		e = x[32];
		if (w) m_write(a, d, e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Ends once pready is seen high; without it only the bench ceiling ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cmp(32'(er), 32'(e));
		if (!w) cmp(rd, x[31:0]);
		@(posedge pclk);
		outs();
	endtask : acc

	task automatic rst();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		m_boot();
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		outs();
	endtask : rst

	initial begin
		int k;
		void'($urandom(32'h7470702d));
		rst();
		for (int a = 0; a <= 48; a += 4) acc(0, 8'(a), 0);
		for (int i = 0; i < 8; i++) acc(1, 8'h00, 32'(i));
		for (int p = 0; p < 4; p++) begin
			acc(1, gcb_pkg::OFS_PITCH, 32'(p));
			for (int c = 0; c < 10; c++) begin
				acc(1, gcb_pkg::OFS_PRESET, $urandom);
				acc(1, 8'(20 + 4 * (c % 2)), 32'(c));
			end
		end
		for (int i = 1; i < 3; i++) acc(1, gcb_pkg::OFS_DIR, 32'(i));
		for (int i = 1; i >= 0; i--) acc(1, 8'h04, 32'(i));
		for (int u = 0; u < 4; u++) begin
			acc(1, gcb_pkg::OFS_TOL, $urandom);
			acc(1, gcb_pkg::OFS_DIR, 32'h00000003);
			acc(1, gcb_pkg::OFS_UNIT, 32'(u));
		end
		repeat (80) begin
			k = $urandom % 12;
			acc($urandom % 2, adr[k], lim[k] ? $urandom % lim[k] : $urandom);
		end
		acc(1, gcb_pkg::OFS_PITCH, 32'h00000002);
		acc(1, gcb_pkg::OFS_RES_A, 32'h00000008);
		acc(1, gcb_pkg::OFS_ABS, 32'h00000001);
		acc(1, gcb_pkg::OFS_MODE, 32'h00000003);
		acc(1, gcb_pkg::OFS_UNIT, 32'h00000001);
		acc(1, gcb_pkg::OFS_MODE, 32'h00000004);
		model_u.move(24'h3A5C71);
		rst();
		acc(1, gcb_pkg::OFS_ABS_ORG, 32'h00000055);
		model_u.move(24'h0F0F0F);
		rst();
		acc(0, gcb_pkg::OFS_ABS_ORG, 0);
		acc(1, gcb_pkg::OFS_NAV, 32'h00000100);
		for (int i = 0; i < 7; i++) begin
			model_u.press();
			nav_idx = (nav_idx + 1) % 6;
			outs();
		end
		// A frozen clock enable must swallow a whole key press
		ce <= 1'b0;
		model_u.press();
		ce <= 1'b1;
		repeat (4) @(posedge pclk);
		outs();
		acc(1, gcb_pkg::OFS_NAV, 32'h00000000);
		model_u.press();
		outs();
		end_sim();
	end
endmodule : test_gauge_counter_basic_params
`default_nettype wire
